/* verification/dac_update_cal_spi_port_tb.sv */
// Self-checking bench for the DAC control serial port.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module dac_update_cal_spi_port_tb;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic iface_sel = 1'h1;
    logic sclk, cs_n, din, dout, dout_oe_n, busy, adc_suspend;
    logic [1:0][11:0] gain = {12'h800, 12'h800};
    logic [1:0][11:0] temp = {12'hc00, 12'h400};
    logic [1:0][11:0] dac_code;
    logic [11:0] temp_reading = 12'hf80;
    logic [3:0] ref_select;
    logic [15:0] rd;
    dac_pkg::spi_pins_s pins;
    int err_total = 0;
    int checked = 0;
    // One row: frame word and the codes and selects it should leave.
    typedef struct {logic [23:0] w; logic [11:0] c0, c1; logic [3:0] r;} row_s;
    row_s rows [10] = '{
        '{24'h00_0123, 12'h000, 12'h000, 4'h0},
        '{24'h06_0001, 12'h123, 12'h000, 4'h0},
        '{24'h03_0abc, 12'h123, 12'habc, 4'h0},
        '{24'h01_0555, 12'h123, 12'habc, 4'h0},
        '{24'h06_0002, 12'h123, 12'h555, 4'h0},
        '{24'h09_000a, 12'h123, 12'h555, 4'ha},
        '{24'h07_0001, 12'h123, 12'h555, 4'ha},
        '{24'h04_0800, 12'ha00, 12'h555, 4'ha},
        '{24'h05_0800, 12'ha00, 12'h555, 4'ha},
        '{24'h06_0002, 12'ha00, 12'h600, 4'ha}};
    assign pins = '{sclk, cs_n, din, iface_sel};
    always #2.5 clk = ~clk;
    spi_master_model u_spi_master_model (.sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe_n(dout_oe_n));
    dac_update_cal_spi_port #(.CAL_CYCLES(16), .RETRACK_CYCLES(32))
        u_dac_update_cal_spi_port (.clk(clk), .reset(reset), .pins(pins),
        .dout(dout), .dout_oe_n(dout_oe_n), .gain_lookup_value(gain),
        .temp_lookup_value(temp), .temp_reading(temp_reading),
        .dac_code(dac_code), .busy(busy), .adc_suspend(adc_suspend),
        .ref_select(ref_select));
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // Waits a bounded number of cycles for busy to reach a level.
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim) begin
            @(posedge clk) #1;
            n++;
        end
        `CHK(busy, lvl)
    endtask : wait_busy
    // Cuts a hang short; the run needs well under a fifth of this.
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clk);
        `CHK({dac_code, busy, ref_select, dout_oe_n}, 30'h0000_0001)
        #1 reset = 1'h0;
        // Rows alternate idle-low and idle-high clocks.
        foreach (rows[i]) begin
            u_spi_master_model.frame(i[0], rows[i].w, 24, rd);
            repeat (10) @(posedge clk);
            `CHK(dac_code[0], rows[i].c0)
            `CHK(dac_code[1], rows[i].c1)
            `CHK(ref_select, rows[i].r)
        end
        u_spi_master_model.frame(1'h0, 24'h8b_0000, 24, rd);
        `CHK(rd, 16'hff80)
        u_spi_master_model.frame(1'h1, 24'h89_0000, 24, rd);
        `CHK(rd, 16'h000a)
        // The released select needs its two sync flops before the enable drops.
        repeat (4) @(posedge clk);
        `CHK(dout_oe_n, 1'h1)
        u_spi_master_model.frame(1'h0, 24'h02_0fff, 20, rd);
        repeat (10) @(posedge clk);
        `CHK(dac_code[0], 12'ha00)
        #1 iface_sel = 1'h0;
        u_spi_master_model.frame(1'h0, 24'h02_0111, 24, rd);
        repeat (10) @(posedge clk);
        `CHK(dac_code[0], 12'ha00)
        #1 iface_sel = 1'h1;
        // Power-up long past; no conversion asked while busy.
        u_spi_master_model.frame(1'h0, 24'h08_0001, 24, rd);
        wait_busy(1'h1, 10);
        `CHK(adc_suspend, 1'h1)
        wait_busy(1'h0, 20);
        repeat (40) @(posedge clk);
        `CHK(busy, 1'h0)
        u_spi_master_model.frame(1'h1, 24'h08_0007, 24, rd);
        wait_busy(1'h1, 10);
        wait_busy(1'h0, 20);
        wait_busy(1'h1, 40);
        u_spi_master_model.frame(1'h0, 24'h08_0000, 24, rd);
        wait_busy(1'h0, 20);
        report_and_stop();
    end
endmodule : dac_update_cal_spi_port_tb

/* verification/spi_master_model.sv */
// Behavioural serial port master that sends framed transfers.
`timescale 1ns/1ps
module spi_master_model (
    // Lines toward the device.
    output logic sclk,
    output logic cs_n,
    output logic din,
    // Return line and its enable.
    input wire logic dout,
    input wire logic dout_oe_n
);
    // Idle: deselected, clock still.
    initial begin
        sclk = 1'h0;
        cs_n = 1'h1;
        din = 1'h0;
    end
    // Sends nbits of a frame, MSB first, half period 24 ns.
    task automatic frame(input bit cpol, input logic [23:0] word,
            input int nbits, output logic [15:0] rd);
        sclk = cpol;
        // Falling select opens the frame.
        #30 cs_n = 1'h0;
        for (int i = 0; i < nbits; i++) begin
            #24 sclk = 1'h0;
            // Read data phase gets a toggling din to prove it is ignored.
            din = (word[23] && i > 7) ? i[0] : word[23 - i];
            #24 sclk = 1'h1;
            // An undriven line reads as unknown so it can never match.
            if (i > 7) rd[23 - i] = dout_oe_n ? 1'hx : dout;
        end
        #24 sclk = cpol;
        // Select stays low over every bit.
        #30 cs_n = 1'h1;
        // Released data line shows the inverse of its last value.
        din = ~din;
    endtask : frame
endmodule : spi_master_model

/* verilog/dac_pkg.sv */
// Shared constants, types and register map of the DAC control serial port.
package dac_pkg;

    // Clock and timing.
    localparam int CLK_PERIOD_PS = 5000;        // System clock period, ps.
    localparam int CAL_TIME_US = 100;           // Calibration run time, us.
    localparam int RETRACK_TIME_US = 1000;      // Tracking interval, us.
    // Cycle counts; a run rounds up, the interval rounds down.
    localparam int CAL_CYCLES =
        (CAL_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RETRACK_CYCLES =
        RETRACK_TIME_US * 1000000 / CLK_PERIOD_PS;

    // Widths.
    localparam int DAC_BITS = 12;               // DAC code width.
    localparam int CHANNELS = 2;                // Independent DAC channels.
    localparam int CMD_BITS = 8;                // Command byte length.
    localparam int DATA_BITS = 16;              // Data word length.
    localparam int FRAME_BITS = 24;             // Whole frame length.

    // Command byte fields.
    localparam int CMD_READ_POS = 7;            // 1 reads, 0 writes.
    localparam int ADDR_BITS = 7;               // Register address width.

    // Register addresses.
    localparam logic [6:0] ADDR_DAC_IN0 = 7'h00;    // Staging, channel 1.
    localparam logic [6:0] ADDR_DAC_IN1 = 7'h01;    // Staging, channel 2.
    localparam logic [6:0] ADDR_DAC_INOUT0 = 7'h02; // Staging+out, ch 1.
    localparam logic [6:0] ADDR_DAC_INOUT1 = 7'h03; // Staging+out, ch 2.
    localparam logic [6:0] ADDR_SETPOINT0 = 7'h04;  // Setpoint, ch 1.
    localparam logic [6:0] ADDR_SETPOINT1 = 7'h05;  // Setpoint, ch 2.
    localparam logic [6:0] ADDR_SW_LOAD = 7'h06;    // Software load.
    localparam logic [6:0] ADDR_SW_CFG = 7'h07;     // Software config.
    localparam logic [6:0] ADDR_CAL_CTRL = 7'h08;   // Calibration control.
    localparam logic [6:0] ADDR_HW_CFG = 7'h09;     // Hardware config.
    localparam logic [6:0] ADDR_STATUS = 7'h0A;     // Busy status.
    localparam logic [6:0] ADDR_TEMP = 7'h0B;       // Temperature reading.

    // Calibration control fields.
    localparam int CAL_REQUEST_POS = 0;         // cal_request_bit.
    localparam int CAL_TRACK_POS = 1;           // Track bit.
    localparam int CAL_SELF_TIMING_POS = 2;     // cal_self_timing_bit.

    // Hardware configuration: reference select in the four low bits.
    localparam int REF_SEL_BITS = 4;

    // Reset values.
    localparam logic [11:0] DAC_RESET = 12'h000;
    localparam logic [2:0] CAL_CTRL_RESET = 3'h0;
    localparam logic [3:0] HW_CFG_RESET = 4'h0;
    localparam logic [1:0] SW_CFG_RESET = 2'h0;

    // Setpoint arithmetic: gain fraction has 12, temp fraction 11 bits.
    localparam int CORR_SHIFT = 23;

    // Serial port pins as seen by the device.
    typedef struct packed {
        logic sclk;       // Serial clock from the master.
        logic cs_n;       // Chip select, active low.
        logic din;        // Serial data in.
        logic iface_sel;  // High selects the four-wire port.
    } spi_pins_s;

    // Calibration sequencer states.
    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_RUN,
        CAL_WAIT
    } cal_state_e;

endpackage : dac_pkg

/* verilog/dac_update_cal_spi_port.sv */
// Dual DAC code control, calibration sequencing and four-wire serial port.
// Operation
// RULE_01: Two independent channels, each a 12-bit code.
// RULE_02: Staging write holds; software load transfers.
// RULE_03: Staging-and-output write updates output at once.
// RULE_04: Setpoint write computes setpoint times corrected gain.
// RULE_05: Gain unsigned fraction, temperature signed fraction.
// RULE_06: Load-select bit picks staging or output target.
// RULE_07: Track low one-shot; all three set tracks.
// RULE_08: ADC activity suspended while calibration runs.
// RULE_09: Busy high during calibration, low after.
// RULE_10: Master waits for busy low before conversions.
// RULE_11: Master calibrates after DAC power-up time.
// RULE_12: Four low hardware config bits select references.
// RULE_13: Select pin low two-wire, high four-wire.
// RULE_14: Clock may idle high or low.
// RULE_15: Master makes clock, limits rate, equal modes.
// RULE_16: Sample input rising, change output falling.
// RULE_17: Chip select fall starts 24-bit frame.
// RULE_18: Command picks register and direction; 16 bits.
// RULE_19: Master holds chip select low whole frame.
// RULE_20: Serial input ignored while read data shifts.
// RULE_21: Temperature reads signed, others unsigned.
// RULE_22: Short frame discarded, no register write.
// RULE_23: Output undriven when deselected or writing.
`timescale 1ns/1ps
module dac_update_cal_spi_port #(
    parameter int CAL_CYCLES = dac_pkg::CAL_CYCLES,
    parameter int RETRACK_CYCLES = dac_pkg::RETRACK_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Serial port pins.
    input dac_pkg::spi_pins_s pins,
    output logic dout,
    output logic dout_oe_n,
    // Lookup results per channel and the temperature reading.
    input wire logic [1:0][11:0] gain_lookup_value,
    input wire logic [1:0][11:0] temp_lookup_value,
    input wire logic [11:0] temp_reading,
    // DAC codes, calibration status and reference selects.
    output logic [1:0][11:0] dac_code,
    output logic busy,
    output logic adc_suspend,
    output logic [3:0] ref_select
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.
    dac_pkg::spi_pins_s pins_q;    // Pins after two flops.
    logic sclk_rise;               // One-cycle pulse on a clock rise.
    logic sclk_fall;               // One-cycle pulse on a clock fall.

    spi_pin_sync u_sync (
        .clk(clk),
        .reset(reset),
        .pins_raw(pins),
        .pins_q(pins_q),
        .sclk_rise(sclk_rise),
        .sclk_fall(sclk_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serial frame engine.
    logic active;                  // Port selected and in four-wire mode.
    logic [4:0] bit_cnt_ff;        // Rising edges seen in this frame.
    logic [22:0] shift_in_ff;      // Bits received so far.
    logic [6:0] addr_ff;           // Latched register address.
    logic rd_active_ff;            // Current frame is a read.
    logic [15:0] rd_shift_ff;      // Read data still to send.
    logic dout_ff;                 // Bit on the serial output.
    logic wr_strobe;               // Completed write frame, one cycle.
    logic [15:0] wr_data;          // Data word of the write.
    logic [6:0] cmd_addr;          // Address as the command completes.
    logic cmd_done;                // Eighth rising edge of the frame.
    logic [15:0] rd_word;          // Read mux output.

    // Two-wire mode leaves this port idle entirely. [RULE_13]
    assign active = ~pins_q.cs_n & pins_q.iface_sel;
    assign cmd_done = active & sclk_rise & (bit_cnt_ff == 5'(dac_pkg::CMD_BITS - 1));
    assign cmd_addr = {shift_in_ff[5:0], pins_q.din};
    // Writes commit only on the final edge, so a short frame is lost. [RULE_22]
    assign wr_strobe = active & sclk_rise & ~rd_active_ff
        & (bit_cnt_ff == 5'(dac_pkg::FRAME_BITS - 1));
    assign wr_data = {shift_in_ff[14:0], pins_q.din};

    // Edge counter; deselect clears it, which starts the next frame. [RULE_17]
    always_ff @(posedge clk) begin
        if (reset || !active) begin
            bit_cnt_ff <= 5'h00;
        end else if (sclk_rise && bit_cnt_ff != 5'(dac_pkg::FRAME_BITS)) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
    end

    // Input is sampled only on rising edges, whatever the idle level.
    always_ff @(posedge clk) begin
        if (reset) begin
            shift_in_ff <= '0;
        end else if (active && sclk_rise) begin
            shift_in_ff <= {shift_in_ff[21:0], pins_q.din}; // [RULE_16] [RULE_14]
        end
    end

    // The command byte names the register and the direction. [RULE_18]
    always_ff @(posedge clk) begin
        if (reset || !active) begin
            rd_active_ff <= 1'b0;
            addr_ff <= 7'h00;
        end else if (cmd_done) begin
            rd_active_ff <= shift_in_ff[dac_pkg::CMD_READ_POS - 1];
            addr_ff <= cmd_addr;
        end
    end

    // Read data loads at the command's end and moves on falling edges;
    // the input level is not looked at meanwhile. [RULE_16] [RULE_20]
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_shift_ff <= 16'h0000;
            dout_ff <= 1'b0;
        end else if (cmd_done) begin
            rd_shift_ff <= rd_word;
        end else if (active && rd_active_ff && sclk_fall) begin
            dout_ff <= rd_shift_ff[15];
            rd_shift_ff <= {rd_shift_ff[14:0], 1'b0};
        end
    end

    // Output released unless a read frame is selected. [RULE_23]
    assign dout = dout_ff;
    assign dout_oe_n = ~(active & rd_active_ff);

    ////////////////////////////////////////////////////////////////////////
    // Control registers.
    logic [1:0] sw_cfg_ff;         // Load-select bit per channel.
    logic [2:0] cal_ctrl_ff;       // Request, track and self-timing bits.
    logic [3:0] hw_cfg_ff;         // Reference source selects.
    logic [1:0][11:0] dac_in_ff;   // Staging codes.
    logic [1:0][11:0] dac_out_ff;  // Active output codes.
    logic [1:0][11:0] setpoint_code_register_ff;     // Setpoint codes.
    logic [1:0] sp_pend_ff;        // Setpoint computation due.
    logic [1:0][11:0] sp_code;     // Computed setpoint codes.
    logic cal_start;               // Calibration run begins.

    // Software configuration and reference selection registers.
    always_ff @(posedge clk) begin
        if (reset) begin
            sw_cfg_ff <= dac_pkg::SW_CFG_RESET;
            hw_cfg_ff <= dac_pkg::HW_CFG_RESET;
        end else if (wr_strobe && addr_ff == dac_pkg::ADDR_SW_CFG) begin
            sw_cfg_ff <= wr_data[1:0];
        end else if (wr_strobe && addr_ff == dac_pkg::ADDR_HW_CFG) begin
            hw_cfg_ff <= wr_data[3:0]; // [RULE_12]
        end
    end

    assign ref_select = hw_cfg_ff;

    // Calibration control; a software write that sets the request wins
    // over the one-shot clear in the same cycle. [RULE_07]
    always_ff @(posedge clk) begin
        if (reset) begin
            cal_ctrl_ff <= dac_pkg::CAL_CTRL_RESET;
        end else if (wr_strobe && addr_ff == dac_pkg::ADDR_CAL_CTRL) begin
            cal_ctrl_ff <= wr_data[2:0];
        end else if (cal_start && !cal_ctrl_ff[dac_pkg::CAL_TRACK_POS]) begin
            cal_ctrl_ff[dac_pkg::CAL_REQUEST_POS] <= 1'b0;
        end
    end

    // Per-channel code registers and setpoint arithmetic. [RULE_01]
    for (genvar ch = 0; ch < dac_pkg::CHANNELS; ch++) begin : g_chan
        logic signed [24:0] kt;      // Gain times temperature fraction.
        logic signed [37:0] prod;    // Setpoint times that product.
        logic signed [15:0] sum;     // Corrected code before clamping.

        // Gain is unsigned, temperature two's complement. [RULE_05]
        assign kt = $signed({1'b0, gain_lookup_value[ch]})
            * $signed(temp_lookup_value[ch]);
        assign prod = $signed({1'b0, setpoint_code_register_ff[ch]}) * kt;
        // Code is setpoint * (1 + k * t), clamped to the code range.
        assign sum = $signed({4'h0, setpoint_code_register_ff[ch]})
            + 16'(prod >>> dac_pkg::CORR_SHIFT); // [RULE_04]
        assign sp_code[ch] = sum[15] ? 12'h000
            : (|sum[14:12]) ? 12'hFFF : sum[11:0];

        // A setpoint write is followed by one computation cycle.
        always_ff @(posedge clk) begin
            if (reset) begin
                setpoint_code_register_ff[ch] <= dac_pkg::DAC_RESET;
                sp_pend_ff[ch] <= 1'b0;
            end else begin
                sp_pend_ff[ch] <= wr_strobe
                    && addr_ff == dac_pkg::ADDR_SETPOINT0 + 7'(ch);
                if (wr_strobe && addr_ff == dac_pkg::ADDR_SETPOINT0 + 7'(ch)) begin
                    setpoint_code_register_ff[ch] <= wr_data[11:0]; // [RULE_04]
                end
            end
        end

        // Staging register: direct writes, combined writes, or setpoint.
        always_ff @(posedge clk) begin
            if (reset) begin
                dac_in_ff[ch] <= dac_pkg::DAC_RESET;
            end else if (wr_strobe && (addr_ff == dac_pkg::ADDR_DAC_IN0 + 7'(ch)
                || addr_ff == dac_pkg::ADDR_DAC_INOUT0 + 7'(ch))) begin
                dac_in_ff[ch] <= wr_data[11:0]; // [RULE_02]
            end else if (sp_pend_ff[ch] && !sw_cfg_ff[ch]) begin
                dac_in_ff[ch] <= sp_code[ch]; // [RULE_06]
            end
        end

        // Output register changes only on load, combined write or setpoint.
        always_ff @(posedge clk) begin
            if (reset) begin
                dac_out_ff[ch] <= dac_pkg::DAC_RESET;
            end else if (wr_strobe
                && addr_ff == dac_pkg::ADDR_DAC_INOUT0 + 7'(ch)) begin
                dac_out_ff[ch] <= wr_data[11:0]; // [RULE_03]
            end else if (wr_strobe && addr_ff == dac_pkg::ADDR_SW_LOAD
                && wr_data[ch]) begin
                dac_out_ff[ch] <= dac_in_ff[ch]; // [RULE_02]
            end else if (sp_pend_ff[ch] && sw_cfg_ff[ch]) begin
                dac_out_ff[ch] <= sp_code[ch]; // [RULE_06]
            end
        end
    end

    assign dac_code = dac_out_ff;

    // Read mux; only the temperature is sign extended. [RULE_21]
    always_comb begin
        case (cmd_addr)
            dac_pkg::ADDR_DAC_IN0: rd_word = {4'h0, dac_in_ff[0]};
            dac_pkg::ADDR_DAC_IN1: rd_word = {4'h0, dac_in_ff[1]};
            dac_pkg::ADDR_DAC_INOUT0: rd_word = {4'h0, dac_out_ff[0]};
            dac_pkg::ADDR_DAC_INOUT1: rd_word = {4'h0, dac_out_ff[1]};
            dac_pkg::ADDR_SETPOINT0: rd_word = {4'h0, setpoint_code_register_ff[0]};
            dac_pkg::ADDR_SETPOINT1: rd_word = {4'h0, setpoint_code_register_ff[1]};
            dac_pkg::ADDR_SW_CFG: rd_word = {14'h0000, sw_cfg_ff};
            dac_pkg::ADDR_CAL_CTRL: rd_word = {13'h0000, cal_ctrl_ff};
            dac_pkg::ADDR_HW_CFG: rd_word = {12'h000, hw_cfg_ff};
            dac_pkg::ADDR_STATUS: rd_word = {15'h0000, busy};
            dac_pkg::ADDR_TEMP: rd_word = {{4{temp_reading[11]}}, temp_reading};
            default: rd_word = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration sequencer. The analog routine is timed here, since the
    // offset trim itself lives outside this logic.
    dac_pkg::cal_state_e cal_state_ff;
    logic [31:0] cal_cnt_ff;       // Cycles spent in the current state.
    logic tracking;                // Track, request and self-timing all set.

    assign tracking = &cal_ctrl_ff;
    assign cal_start = (cal_state_ff == dac_pkg::CAL_IDLE)
        && cal_ctrl_ff[dac_pkg::CAL_REQUEST_POS];

    // One-shot runs once; tracking reruns after each interval. [RULE_07]
    always_ff @(posedge clk) begin
        if (reset) begin
            cal_state_ff <= dac_pkg::CAL_IDLE;
            cal_cnt_ff <= 32'h0000_0000;
        end else begin
            case (cal_state_ff)
                dac_pkg::CAL_IDLE: begin
                    cal_cnt_ff <= 32'h0000_0000;
                    if (cal_start) begin
                        cal_state_ff <= dac_pkg::CAL_RUN;
                    end
                end
                dac_pkg::CAL_RUN: begin
                    if (cal_cnt_ff == 32'(CAL_CYCLES - 1)) begin
                        cal_cnt_ff <= 32'h0000_0000;
                        cal_state_ff <= tracking ? dac_pkg::CAL_WAIT
                            : dac_pkg::CAL_IDLE;
                    end else begin
                        cal_cnt_ff <= cal_cnt_ff + 32'h0000_0001;
                    end
                end
                dac_pkg::CAL_WAIT: begin
                    // Dropping out of tracking ends the wait at once.
                    if (!tracking || cal_cnt_ff == 32'(RETRACK_CYCLES - 1)) begin
                        cal_cnt_ff <= 32'h0000_0000;
                        cal_state_ff <= dac_pkg::CAL_IDLE;
                    end else begin
                        cal_cnt_ff <= cal_cnt_ff + 32'h0000_0001;
                    end
                end
                default: begin
                    cal_state_ff <= dac_pkg::CAL_IDLE;
                end
            endcase
        end
    end

    // Busy and the ADC hold follow the run state exactly. [RULE_09] [RULE_08]
    assign busy = (cal_state_ff == dac_pkg::CAL_RUN);
    assign adc_suspend = busy;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    staged_hold_a: assert property (wr_strobe && addr_ff == dac_pkg::ADDR_DAC_IN0 |=> $stable(dac_code[0]) && dac_in_ff[0] == $past(wr_data[11:0])) else $error("staging write moved output"); // [RULE_02]
    load_xfer_a: assert property (wr_strobe && addr_ff == dac_pkg::ADDR_SW_LOAD && wr_data[1] |=> dac_code[1] == $past(dac_in_ff[1])) else $error("software load missed"); // [RULE_02]
    direct_out_a: assert property (wr_strobe && addr_ff == dac_pkg::ADDR_DAC_INOUT1 |=> dac_code[1] == $past(wr_data[11:0])) else $error("combined write not applied"); // [RULE_03]
    setpoint_route_a: assert property (wr_strobe && addr_ff == dac_pkg::ADDR_SETPOINT0 && sw_cfg_ff[0] |=> ##1 dac_code[0] == $past(sp_code[0])) else $error("setpoint code not output"); // [RULE_06]
    cal_end_a: assert property (busy && cal_cnt_ff == 32'(CAL_CYCLES - 1) |=> !busy && !adc_suspend) else $error("busy held past run"); // [RULE_09]
    cal_begin_a: assert property (cal_start |=> busy && adc_suspend) else $error("calibration did not start"); // [RULE_08]
    dout_release_a: assert property (pins_q.cs_n || !rd_active_ff |-> dout_oe_n) else $error("output driven when idle"); // [RULE_23]
    short_frame_a: assert property ($rose(pins_q.cs_n) |-> !wr_strobe ##1 bit_cnt_ff == 5'h00) else $error("partial frame kept"); // [RULE_22]
    read_shift_a: assert property (active && rd_active_ff && sclk_fall |=> dout == $past(rd_shift_ff[15])) else $error("read bit wrong"); // [RULE_16]
    ref_sel_a: assert property (wr_strobe && addr_ff == dac_pkg::ADDR_HW_CFG |=> ref_select == $past(wr_data[3:0])) else $error("reference select not stored"); // [RULE_12]
    two_wire_a: assert property (!pins_q.iface_sel |-> ##1 bit_cnt_ff == 5'h00 && dout_oe_n) else $error("port active in two-wire mode"); // [RULE_13]

    write_frame_c: cover property (wr_strobe);
    read_frame_c: cover property (cmd_done && shift_in_ff[dac_pkg::CMD_READ_POS - 1]);
    cal_done_c: cover property (busy ##1 !busy);
    retrack_c: cover property (cal_state_ff == dac_pkg::CAL_WAIT);

endmodule : dac_update_cal_spi_port

/* verilog/spi_pin_sync.sv */
// Two-stage synchroniser for the serial port pins, with clock edge finding.
`timescale 1ns/1ps
module spi_pin_sync (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Raw pins.
    input dac_pkg::spi_pins_s pins_raw,
    // Synchronised pins and serial clock edges.
    output dac_pkg::spi_pins_s pins_q,
    output logic sclk_rise,
    output logic sclk_fall
);

    ////////////////////////////////////////////////////////////////////////
    dac_pkg::spi_pins_s meta_ff;   // First stage, read only by stage two.
    dac_pkg::spi_pins_s sync_ff;   // Second stage, safe to use.
    logic sclk_prev_ff;            // Delayed serial clock for edges.

    // Both stages reset to an idle bus: chip select high, clock low.
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_ff <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0, iface_sel: 1'b0};
            sync_ff <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0, iface_sel: 1'b0};
        end else begin
            meta_ff <= pins_raw;
            sync_ff <= meta_ff;
        end
    end

    // A third flop lets edges be found without touching the first stage.
    always_ff @(posedge clk) begin
        if (reset) begin
            sclk_prev_ff <= 1'b0;
        end else begin
            sclk_prev_ff <= sync_ff.sclk;
        end
    end

    assign pins_q = sync_ff;
    assign sclk_rise = sync_ff.sclk & ~sclk_prev_ff;
    assign sclk_fall = ~sync_ff.sclk & sclk_prev_ff;

endmodule : spi_pin_sync
